// ===== rtl/master_port_defs.svh
`ifndef MASTER_PORT_DEFS_SVH
`define MASTER_PORT_DEFS_SVH

`define WORD_W 16
`define NARROW_W 8
`define DIV_SEL_W 2
`define DIV_CNT_W 4
`define DIV_ONE 4'h1
`define TX_DEPTH_DEF 8
`define RX_DEPTH_DEF 8
`define COUNT_W 8
`define SKID_DEPTH 2
`define SYNC_W 18
`define RESET_ONE 1'b1
`define RESET_ZERO 1'b0
`define WORD_ZERO 16'h0000
`define BYTE_MASK 16'h00ff
`define FULL_MASK 16'hffff

`endif

// ===== rtl/master_port_pkg.sv
package master_port_pkg;

  // Static configuration, expected to change only while the port is idle
  typedef struct packed {
    logic wide;
    logic master;
    logic media;
    logic clk_out;
    logic [1:0] div_sel;
  } port_cfg_t;

  typedef enum logic [1:0] {
    OP_IDLE,
    OP_WRITE,
    OP_MREAD
  } op_state_t;

  typedef struct packed {
    logic link;
    logic dir;
    logic [15:0] data;
  } pin_in_t;

endpackage

// ===== rtl/sync_bits.sv
`timescale 1ns/100ps
module sync_bits #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule // sync_bits

// ===== rtl/word_queue.sv
`timescale 1ns/100ps
module word_queue #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8,
  parameter int CW = $clog2(DEPTH + 1)
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [CW-1:0] count
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  logic full_q;
  logic empty_q;
  wire push = in_valid && !full_q;
  wire pop = out_ready && !empty_q;
  wire [CW-1:0] cnt_d = cnt_q + CW'(push) - CW'(pop);
  wire [AW-1:0] wr_nx = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
  wire [AW-1:0] rd_nx = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      full_q <= 1'b0;
      empty_q <= 1'b1;
    end else begin
      if (push) wr_q <= wr_nx;
      if (pop) rd_q <= rd_nx;
      cnt_q <= cnt_d;
      full_q <= (cnt_d == CW'(DEPTH));
      empty_q <= (cnt_d == '0);
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem_q[wr_q] <= in_data;
  end

  assign in_ready = !full_q;
  assign out_valid = !empty_q;
  assign out_data = mem_q[rd_q];
  assign count = cnt_q;
endmodule // word_queue

// ===== rtl/master_port.sv
`include "master_port_defs.svh"
`timescale 1ns/100ps
module master_port #(
  parameter int TX_DEPTH = `TX_DEPTH_DEF,
  parameter int RX_DEPTH = `RX_DEPTH_DEF,
  parameter int RX_CW = $clog2(RX_DEPTH + 1),
  parameter int TX_CW = $clog2(TX_DEPTH + 1)
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire master_port_pkg::port_cfg_t cfg,
  input wire logic [`COUNT_W-1:0] burst_count,
  input wire logic [RX_CW-1:0] rx_watermark,
  input wire logic write_start,
  input wire logic mread_start,
  output logic op_busy,
  output logic write_done,
  output logic overflow,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [`WORD_W-1:0] tx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [`WORD_W-1:0] rx_data,
  input wire logic [`WORD_W-1:0] port_data_bus_in,
  output logic [`WORD_W-1:0] port_data_bus_out,
  output logic port_data_bus_oe,
  input wire logic link_clock_or_select_in,
  output logic link_clock_or_select_out,
  output logic link_clock_or_select_oe,
  input wire logic direction_line_in,
  output logic direction_line_out,
  output logic direction_line_oe,
  output logic read_strobe_out,
  output logic read_request_out,
  output logic receive_full_out,
  output logic wait_n
);
  master_port_pkg::pin_in_t pin_raw;
  master_port_pkg::pin_in_t pin_s;
  master_port_pkg::op_state_t op_q;
  master_port_pkg::op_state_t op_d;

  logic link_prev_q;
  logic [`DIV_CNT_W-1:0] div_cnt_q;
  logic link_out_q;
  logic [`WORD_W-1:0] data_out_q;
  logic data_oe_q;
  logic read_request_q;
  logic receive_full_q;
  logic wait_n_q;
  logic read_strobe_q;
  logic overflow_q;
  logic write_done_q;
  logic [`COUNT_W-1:0] words_q;
  logic busy_q;

  logic tx_q_valid;
  logic [`WORD_W-1:0] tx_q_data;
  logic [TX_CW-1:0] tx_count;
  logic rx_in_ready;
  logic [RX_CW-1:0] rx_count;
  logic rx_q_valid;
  logic [`WORD_W-1:0] rx_q_data;
  logic skid_in_ready;
  logic tx_in_ready;

  assign pin_raw.link = link_clock_or_select_in;
  assign pin_raw.dir = direction_line_in;
  assign pin_raw.data = port_data_bus_in;

  // All pin inputs cross two flops before any decode
  sync_bits #(
    .WIDTH(`SYNC_W)
  ) u_pin_sync (
    .clk(clk),
    .rst_b(rst_b),
    .async_i(pin_raw),
    .sync_o(pin_s)
  );

  // Mode decode
  wire port_on = cfg.media;
  wire drive_link = cfg.master || cfg.clk_out;
  wire ext_clk_mode = cfg.media && !cfg.master && !cfg.clk_out;
  wire [`WORD_W-1:0] width_mask = cfg.wide ? `FULL_MASK : `BYTE_MASK;

  // Divided link clock; half period is 1, 2, 4 or 8 system cycles
  wire [`DIV_CNT_W-1:0] half_m1 = (`DIV_ONE << cfg.div_sel) - `DIV_ONE;
  wire div_wrap = drive_link && (div_cnt_q == half_m1);
  wire own_rise = div_wrap && !link_out_q;

  // Link edge from the synchronised pin or from the own divider
  wire ext_rise = pin_s.link && !link_prev_q;
  wire link_edge = (port_on && drive_link && own_rise) || (ext_clk_mode && ext_rise);

  // Slave cycles: sampled direction high reads the transmit queue
  wire slave_edge = link_edge && !cfg.master;
  wire read_edge = slave_edge && pin_s.dir;
  wire write_edge = slave_edge && !pin_s.dir;
  wire mread_edge = link_edge && cfg.master && (op_q == master_port_pkg::OP_MREAD);
  wire capture = write_edge || mread_edge;
  wire tx_pop = read_edge && tx_q_valid;
  wire rx_push = capture && rx_in_ready;
  wire rx_drop = capture && !rx_in_ready;
  wire burst_word = capture && (op_q != master_port_pkg::OP_IDLE);
  wire burst_last = burst_word && (words_q == burst_count);

  wire [TX_CW-1:0] tx_count_nx = tx_count - TX_CW'(tx_pop);
  wire stall = port_on && !cfg.master
    && (pin_s.dir ? !tx_q_valid : !rx_in_ready);

  word_queue #(
    .WIDTH(`WORD_W),
    .DEPTH(TX_DEPTH)
  ) u_tx_queue (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(tx_valid),
    .in_ready(tx_in_ready),
    .in_data(tx_data),
    .out_valid(tx_q_valid),
    .out_ready(tx_pop),
    .out_data(tx_q_data),
    .count(tx_count)
  );

  // Words are accepted any time; a full queue drops them
  word_queue #(
    .WIDTH(`WORD_W),
    .DEPTH(RX_DEPTH)
  ) u_rx_queue (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(rx_push),
    .in_ready(rx_in_ready),
    .in_data(pin_s.data & width_mask),
    .out_valid(rx_q_valid),
    .out_ready(skid_in_ready),
    .out_data(rx_q_data),
    .count(rx_count)
  );

  // Two-entry buffer lets the reader stall without losing a word
  word_queue #(
    .WIDTH(`WORD_W),
    .DEPTH(`SKID_DEPTH)
  ) u_rx_skid (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(rx_q_valid),
    .in_ready(skid_in_ready),
    .in_data(rx_q_data),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data),
    .count()
  );

  // Operation sequencing
  always_comb begin
    op_d = op_q;
    case (op_q)
      master_port_pkg::OP_IDLE: begin
        if (mread_start && cfg.master) begin
          op_d = master_port_pkg::OP_MREAD;
        end else if (write_start && !cfg.master) begin
          op_d = master_port_pkg::OP_WRITE;
        end
      end
      master_port_pkg::OP_WRITE,
      master_port_pkg::OP_MREAD: begin
        if (burst_last) begin
          op_d = master_port_pkg::OP_IDLE;
        end
      end
      default: begin
        op_d = master_port_pkg::OP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      op_q <= master_port_pkg::OP_IDLE;
      words_q <= '0;
      write_done_q <= `RESET_ZERO;
    end else begin
      op_q <= op_d;
      write_done_q <= burst_last;
      if (op_q == master_port_pkg::OP_IDLE || burst_last) begin
        words_q <= '0;
      end else if (burst_word) begin
        words_q <= words_q + 1'b1;
      end
    end
  end

  // Link clock divider and edge memory
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      div_cnt_q <= '0;
      link_out_q <= `RESET_ZERO;
      link_prev_q <= `RESET_ZERO;
    end else begin
      link_prev_q <= pin_s.link;
      if (!drive_link || div_wrap) begin
        div_cnt_q <= '0;
      end else begin
        div_cnt_q <= div_cnt_q + 1'b1;
      end
      if (div_wrap) begin
        link_out_q <= !link_out_q;
      end else if (!drive_link) begin
        link_out_q <= `RESET_ZERO;
      end
    end
  end

  // Drivers on at a read edge; off once direction reads low, so an external write meets no driver
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      data_out_q <= `WORD_ZERO;
      data_oe_q <= `RESET_ZERO;
    end else begin
      if (tx_pop) begin
        data_out_q <= tx_q_data & width_mask;
        data_oe_q <= `RESET_ONE;
      end else if (capture || !port_on || cfg.master || !pin_s.dir) begin
        data_oe_q <= `RESET_ZERO;
      end
    end
  end

  // Status pins; the request falls the cycle after the last pop
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      read_request_q <= `RESET_ZERO;
      receive_full_q <= `RESET_ZERO;
      wait_n_q <= `RESET_ONE;
      read_strobe_q <= `RESET_ONE;
      overflow_q <= `RESET_ZERO;
      busy_q <= `RESET_ZERO;
    end else begin
      read_request_q <= port_on && (tx_count_nx != '0);
      receive_full_q <= (rx_count >= rx_watermark);
      wait_n_q <= !stall;
      read_strobe_q <= !(cfg.master && op_q == master_port_pkg::OP_MREAD);
      overflow_q <= rx_drop;
      busy_q <= (op_d != master_port_pkg::OP_IDLE);
    end
  end

  // Direction is ours only in master mode, and then it means read
  assign direction_line_out = `RESET_ZERO;
  assign direction_line_oe = cfg.master;
  assign link_clock_or_select_out = link_out_q;
  assign link_clock_or_select_oe = drive_link;
  assign port_data_bus_out = data_out_q;
  assign port_data_bus_oe = data_oe_q;
  assign read_request_out = read_request_q;
  assign receive_full_out = receive_full_q;
  assign wait_n = wait_n_q;
  assign read_strobe_out = read_strobe_q;
  assign overflow = overflow_q;
  assign write_done = write_done_q;
  assign op_busy = busy_q;
  assign tx_ready = tx_in_ready;

  // Checks
  property p_strobe_slave;
    @(posedge clk) disable iff (!rst_b)
      !cfg.master |=> read_strobe_q;
  endproperty
  a_strobe_slave: assert property (p_strobe_slave)
    else $error("read strobe low in slave mode");

  property p_req_on;
    @(posedge clk) disable iff (!rst_b)
      (port_on && tx_count_nx != '0) |=> read_request_q;
  endproperty
  a_req_on: assert property (p_req_on)
    else $error("read request missing with data queued");

  sequence s_last_pop;
    tx_pop && tx_count == TX_CW'(1) && !(tx_valid && tx_in_ready);
  endsequence

  property p_req_off;
    @(posedge clk) disable iff (!rst_b)
      s_last_pop |=> !read_request_q;
  endproperty
  a_req_off: assert property (p_req_off)
    else $error("read request not dropped after last word");

  property p_rx_full;
    @(posedge clk) disable iff (!rst_b)
      (rx_count >= rx_watermark) |=> receive_full_q;
  endproperty
  a_rx_full: assert property (p_rx_full)
    else $error("receive full not raised at watermark");

  property p_drive_word;
    @(posedge clk) disable iff (!rst_b)
      tx_pop |=> data_oe_q && data_out_q == ($past(tx_q_data) & $past(width_mask));
  endproperty
  a_drive_word: assert property (p_drive_word)
    else $error("transmit word not driven at read edge");

  property p_drop;
    @(posedge clk) disable iff (!rst_b)
      rx_drop |=> overflow_q ##1 !overflow_q || $past(rx_drop);
  endproperty
  a_drop: assert property (p_drop)
    else $error("overflow not flagged for dropped word");

  property p_dir_master;
    @(posedge clk) disable iff (!rst_b)
      cfg.master |-> direction_line_oe && !direction_line_out;
  endproperty
  a_dir_master: assert property (p_dir_master)
    else $error("direction line not driven in master mode");

  property p_div_toggle;
    @(posedge clk) disable iff (!rst_b)
      div_wrap |=> link_out_q != $past(link_out_q);
  endproperty
  a_div_toggle: assert property (p_div_toggle)
    else $error("link clock did not toggle at divider wrap");

  property p_wait;
    @(posedge clk) disable iff (!rst_b)
      (port_on && !cfg.master && pin_s.dir && !tx_q_valid) |=> !wait_n_q;
  endproperty
  a_wait: assert property (p_wait)
    else $error("wait not asserted while read data missing");

  property p_burst_done;
    @(posedge clk) disable iff (!rst_b)
      burst_last |=> write_done_q && op_q == master_port_pkg::OP_IDLE;
  endproperty
  a_burst_done: assert property (p_burst_done)
    else $error("burst did not finish after count plus one words");

  property p_bus_release;
    @(posedge clk) disable iff (!rst_b)
      (port_on && !cfg.master && !pin_s.dir) |=> !data_oe_q;
  endproperty
  a_bus_release: assert property (p_bus_release)
    else $error("data drivers left on during external write");
endmodule // master_port

// ===== verification/media_model.sv
`timescale 1ns/100ps
module media_model (
  input wire logic clk,
  input wire logic [15:0] bus,
  input wire logic bus_oe,
  input wire logic req,
  input wire logic pat,
  output logic link,
  output logic dir,
  output logic [15:0] data
);
  initial begin
    link = 1'b0;
    dir = 1'b0;
    data = 16'h0000;
  end
  // Slave of a master read: a changing pattern, so nothing stale passes
  always @(posedge clk) begin
    if (pat) begin
      data <= data + 16'h3b5d;
    end
  end
  // Link high 6 and low 6 clk, above the 3 clk the port needs to see a phase
  task automatic cycle(input logic wr, input logic [15:0] w, output logic [15:0] r,
                       output logic o);
    if (!wr) begin
      repeat (40) if (req !== 1'b1) @(posedge clk);
    end
    dir <= !wr;
    if (wr) begin
      data <= w;
    end
    // Two clk of setup; the port lets go of the data bus one clk after the link rises
    repeat (2) @(posedge clk);
    link <= 1'b1;
    repeat (6) @(posedge clk);
    r = bus;
    o = bus_oe;
    link <= 1'b0;
    repeat (3) @(posedge clk);
    data <= ~data;
    @(posedge clk);
  endtask
endmodule // media_model

// ===== verification/testbench.sv
`timescale 1ns/100ps
module testbench;
  localparam int RXD = 4;
  localparam int CW = $clog2(RXD + 1);
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  master_port_pkg::port_cfg_t cfg = 6'h28;
  logic [7:0] burst_count = 8'h02;
  logic [CW-1:0] rx_watermark = 3'h2;
  logic write_start = 1'b0;
  logic mread_start = 1'b0;
  logic tx_valid = 1'b0;
  logic rx_ready = 1'b0;
  logic hold_rx = 1'b0;
  logic chk_rx = 1'b1;
  logic pat = 1'b0;
  logic [15:0] tx_data = 16'h0000;
  logic [15:0] seed = 16'h66ab;
  logic op_busy, write_done, overflow, tx_ready, rx_valid, bus_oe, link_out, link_oe;
  logic dir_out, dir_oe, strobe_n, req, full, wait_n, ext_link, ext_dir, o, lp;
  logic [15:0] rx_data, bus_out, ext_data, rd, w;
  logic [15:0] arr [12];
  int bad_count, checked, cyc, ovf, dones, cnt, n, got;
  logic [15:0] exp_rx[$];
  wire [15:0] data_w = bus_oe ? bus_out : ext_data;
  wire link_w = link_oe ? link_out : ext_link;
  wire dir_w = dir_oe ? dir_out : ext_dir;

  master_port #(.RX_DEPTH(RXD)) dut (.clk(clk), .rst_b(rst_b), .cfg(cfg),
    .burst_count(burst_count), .rx_watermark(rx_watermark), .write_start(write_start),
    .mread_start(mread_start), .op_busy(op_busy), .write_done(write_done),
    .overflow(overflow), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .port_data_bus_in(data_w), .port_data_bus_out(bus_out), .port_data_bus_oe(bus_oe),
    .link_clock_or_select_in(link_w), .link_clock_or_select_out(link_out),
    .link_clock_or_select_oe(link_oe), .direction_line_in(dir_w),
    .direction_line_out(dir_out), .direction_line_oe(dir_oe), .read_strobe_out(strobe_n),
    .read_request_out(req), .receive_full_out(full), .wait_n(wait_n));
  media_model m (.clk(clk), .bus(data_w), .bus_oe(bus_oe), .req(req), .pat(pat),
    .link(ext_link), .dir(ext_dir), .data(ext_data));

  always #5 clk = ~clk;

  function automatic logic [15:0] nxt();
    seed = seed ^ (seed << 7);
    seed = seed ^ (seed >> 9);
    seed = seed ^ (seed << 8);
    return seed;
  endfunction
  task automatic fail(input string s);
    bad_count++;
    $display("[FAIL] %0t %s", $time, s);
  endtask
  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) fail("word mismatch");
  endtask
  task automatic chk_flag(input logic g, input logic e);
    checked++;
    if (g !== e) fail("flag mismatch");
  endtask
  task automatic summarize();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic push(input logic [15:0] v);
    tx_valid <= 1'b1;
    tx_data <= v;
    @(posedge clk);
    while (tx_ready !== 1'b1) @(posedge clk);
    tx_valid <= 1'b0;
    @(posedge clk);
  endtask

  // Receiver stalls at random, so the two-entry buffer gets exercised
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      fail("timeout");
      summarize();
    end
    if (overflow === 1'b1) ovf++;
    if (write_done === 1'b1) dones++;
    if (rx_valid === 1'b1 && rx_ready === 1'b1 && !chk_rx) got++;
    if (rx_valid === 1'b1 && rx_ready === 1'b1 && chk_rx) begin
      if (exp_rx.size() == 0) fail("unexpected word");
      else chk_word(rx_data, exp_rx.pop_front());
    end
    rx_ready <= !hold_rx && nxt() > 16'h5000;
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    chk_flag(link_oe, 1'b0);
    chk_flag(dir_oe, 1'b0);
    chk_flag(strobe_n, 1'b1);
    chk_flag(req, 1'b0);
    chk_flag(tx_ready, 1'b1);
    for (int i = 0; i < 3; i++) begin
      arr[i] = nxt();
      push(arr[i]);
    end
    repeat (3) @(posedge clk);
    chk_flag(req, 1'b1);
    for (int i = 0; i < 3; i++) begin
      m.cycle(1'b0, 16'h0000, rd, o);
      chk_flag(o, 1'b1);
      chk_word(rd, arr[i]);
    end
    chk_flag(req, 1'b0);
    chk_flag(wait_n, 1'b0);
    cfg <= 6'h08;
    w = nxt();
    push(w);
    m.cycle(1'b0, 16'h0000, rd, o);
    chk_word(rd, w & 16'h00ff);
    exp_rx.push_back(w & 16'h00ff);
    m.cycle(1'b1, w, rd, o);
    cfg <= 6'h28;
    write_start <= 1'b1;
    @(posedge clk);
    write_start <= 1'b0;
    dones = 0;
    for (int i = 0; i < 3; i++) begin
      w = nxt();
      exp_rx.push_back(w);
      if (i == 2) chk_flag(op_busy, 1'b1);
      m.cycle(1'b1, w, rd, o);
    end
    chk_flag(op_busy, 1'b0);
    chk_word(16'(dones), 16'h0001);
    repeat (40) @(posedge clk);
    chk_flag(full, 1'b0);
    hold_rx <= 1'b1;
    ovf = 0;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 12; i++) begin
      arr[i] = nxt();
      m.cycle(1'b1, arr[i], rd, o);
    end
    chk_flag(full, 1'b1);
    chk_flag(wait_n, 1'b0);
    chk_word(16'(ovf), 16'(12 - RXD - 2));
    for (int i = 0; i < 12 - ovf; i++) exp_rx.push_back(arr[i]);
    hold_rx <= 1'b0;
    repeat (80) @(posedge clk);
    chk_word(16'(exp_rx.size()), 16'h0000);
    chk_flag(wait_n, 1'b1);
    chk_rx <= 1'b0;
    pat <= 1'b1;
    burst_count <= 8'h03;
    for (int d = 0; d < 4; d++) begin
      cfg <= 6'h3c | 6'(d);
      dones = 0;
      got = 0;
      n = 0;
      lp = 1'b0;
      repeat (3) @(posedge clk);
      mread_start <= 1'b1;
      @(posedge clk);
      mread_start <= 1'b0;
      repeat (2) @(posedge clk);
      chk_flag(strobe_n, 1'b0);
      chk_flag(dir_oe & ~dir_out, 1'b1);
      chk_flag(link_oe, 1'b1);
      repeat (200) begin
        @(posedge clk);
        cnt++;
        if (link_out === 1'b1 && lp === 1'b0) begin
          if (n > 0) chk_word(16'(cnt), 16'(2 << d));
          n++;
          cnt = 0;
        end
        lp = link_out;
      end
      chk_word(16'(dones), 16'h0001);
      chk_word(16'(got), 16'h0004);
      chk_flag(strobe_n, 1'b1);
    end
    summarize();
  end
endmodule // testbench
